// ### pcw_pkg.sv
// Constants, field layout and event codes of the per-pin control word block.
// Assumes a 32-bit register port with byte addresses and a single 40 MHz clock.
//
// Operation
// - Bits 31:25 and 23:20 read zero; writes to them are ignored.
// - Flag bit 24 sets when the selected pin event is seen.
// - Without DMA mode, flag holds until software writes one to it.
// - In DMA mode, a finished DMA transfer clears the flag automatically.
// - Level modes set the flag again at once while the level persists.
// - Pins without event capability keep flag and event select read-only.
// - Event detection works in every mux slot, not only general I/O.
// - Event select sits in bits 19:16; code 0000 disables everything.
// - Code 0001 flags and requests DMA on each rising edge.
// - Code 0010 flags and requests DMA on each falling edge.
// - Code 0011 flags and requests DMA on both edges.
// - Codes 1000..1100 flag and interrupt on low, rise, fall, either, high.
// - Pin words sit at base plus four times pin index, pins 0..31.
// - Unbonded pins leave reset with the mux in the disabled slot.
// - Mux and single-bit pad fields have per-port reset values.
// - Mux field bits 10:8; bits 15:11 reserved and read zero.

package pcw_pkg;

  // ==========================================================================
  // Register map
  localparam int          PCW_ADDR_W      = 8;
  localparam int          PCW_DATA_W      = 32;
  localparam int          PCW_PIN_IDX_W   = 5;
  localparam int          PCW_IDX_LSB     = 2;
  localparam int          PCW_AREA_BIT    = 7;
  localparam logic [7:0]  PCW_OFS_STATUS  = 8'hA0;
  localparam logic [7:0]  PCW_OFS_MASK    = 8'hA4;

  // ==========================================================================
  // Field positions of a pin control word
  localparam int          PCW_FLAG_BIT    = 24;
  localparam int          PCW_SEL_LSB     = 16;
  localparam int          PCW_SEL_W       = 4;
  localparam int          PCW_MUX_LSB     = 8;
  localparam int          PCW_MUX_W       = 3;
  localparam int          PCW_DRIVE_BIT   = 6;
  localparam int          PCW_FILTER_BIT  = 4;
  localparam int          PCW_SLEW_BIT    = 2;
  localparam int          PCW_PULL_BIT    = 1;
  localparam int          PCW_PDIR_BIT    = 0;

  // Mux slot that switches the pad off
  localparam logic [2:0]  PCW_MUX_DISABLE = 3'h0;

  // ==========================================================================
  // Event select codes
  localparam logic [3:0]  PCW_EV_OFF      = 4'h0;
  localparam logic [3:0]  PCW_EV_DMA_RISE = 4'h1;
  localparam logic [3:0]  PCW_EV_DMA_FALL = 4'h2;
  localparam logic [3:0]  PCW_EV_DMA_BOTH = 4'h3;
  localparam logic [3:0]  PCW_EV_IRQ_LOW  = 4'h8;
  localparam logic [3:0]  PCW_EV_IRQ_RISE = 4'h9;
  localparam logic [3:0]  PCW_EV_IRQ_FALL = 4'hA;
  localparam logic [3:0]  PCW_EV_IRQ_BOTH = 4'hB;
  localparam logic [3:0]  PCW_EV_IRQ_HIGH = 4'hC;

endpackage

// ### pcw_pin_if.sv
// Signals between the register block and one pin's event detector.
// Assumes both ends run on the same clock.

`timescale 1ns/1ps

interface pcw_pin_if;
  logic [3:0] event_select;
  logic       pin_level;
  logic       sw_clear;
  logic       dma_done;
  logic       pin_event_flag;
  logic       dma_req;
  logic       irq_req;

  modport ctrl (output event_select, pin_level, sw_clear, dma_done,
                input  pin_event_flag, dma_req, irq_req);
  modport det  (input  event_select, pin_level, sw_clear, dma_done,
                output pin_event_flag, dma_req, irq_req);
endinterface

// ### pcw_sync.sv
// Two-stage synchroniser for a vector of pin inputs.
// Assumes the inputs are asynchronous to clk.

`timescale 1ns/1ps

module pcw_sync
  import pcw_pkg::*;
#(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage1 <= '0;
      q      <= '0;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end
endmodule

// ### pcw_pin_detect.sv
// Edge and level detector with the sticky event flag of one pin.
// Assumes a pin level already synchronised to clk.

`timescale 1ns/1ps

module pcw_pin_detect
  import pcw_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Link to the register block
  pcw_pin_if.det    p
);

  logic prev_level;
  logic rise;
  logic fall;
  logic dma_mode;
  logic irq_mode;
  logic hit;
  logic clear;

  // Edges from the delayed copy of the level
  assign rise = p.pin_level & ~prev_level;
  assign fall = ~p.pin_level & prev_level;

  // DMA codes are 1..3, interrupt codes 8..C
  assign dma_mode = (p.event_select == PCW_EV_DMA_RISE) ||
                    (p.event_select == PCW_EV_DMA_FALL) ||
                    (p.event_select == PCW_EV_DMA_BOTH);
  assign irq_mode = (p.event_select >= PCW_EV_IRQ_LOW) &&
                    (p.event_select <= PCW_EV_IRQ_HIGH);

  // Event decode; reserved codes and code 0 never hit
  always_comb begin
    case (p.event_select)
      PCW_EV_DMA_RISE: hit = rise;
      PCW_EV_DMA_FALL: hit = fall;
      PCW_EV_DMA_BOTH: hit = rise | fall;
      PCW_EV_IRQ_LOW:  hit = ~p.pin_level;
      PCW_EV_IRQ_RISE: hit = rise;
      PCW_EV_IRQ_FALL: hit = fall;
      PCW_EV_IRQ_BOTH: hit = rise | fall;
      PCW_EV_IRQ_HIGH: hit = p.pin_level;
      default:         hit = 1'b0;
    endcase
  end

  // DMA completion clears in DMA mode, write-one clears always
  assign clear = p.sw_clear | (dma_mode & p.dma_done);

  // Level history
  always_ff @(posedge clk) begin
    if (sys_rst) prev_level <= 1'b0;
    else         prev_level <= p.pin_level;
  end

  // Sticky flag; a hit in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (sys_rst)    p.pin_event_flag <= 1'b0;
    else if (hit)   p.pin_event_flag <= 1'b1;
    else if (clear) p.pin_event_flag <= 1'b0;
  end

  // Requests follow the flag and the mode
  assign p.dma_req = p.pin_event_flag & dma_mode;
  assign p.irq_req = p.pin_event_flag & irq_mode;
endmodule

// ### pcw_port.sv
// Port of pin control words: register port, pad configuration outputs,
// per-pin event detection and the port interrupt and DMA request outputs.
// Assumes pin inputs asynchronous to clk and a one-cycle register port
// whose read data appear in the cycle after the read strobe.
//
// The plain strobed port was decided locally.

`timescale 1ns/1ps

module pcw_port
  import pcw_pkg::*;
#(
  parameter int                    NUM_PINS    = 32,
  parameter logic [NUM_PINS-1:0]   IRQ_CAPABLE = '1,
  parameter logic [NUM_PINS-1:0]   BONDED      = '1,
  parameter logic [2:0]            RST_MUX     = 3'h0,
  parameter logic                  RST_DRIVE   = 1'b0,
  parameter logic                  RST_FILTER  = 1'b0,
  parameter logic                  RST_SLEW    = 1'b0,
  parameter logic                  RST_PULL    = 1'b0,
  parameter logic                  RST_PDIR    = 1'b0
) (
  // Clock and reset
  input  wire logic                              clk,
  input  wire logic                              sys_rst,
  // Register port
  input  wire logic [PCW_ADDR_W-1:0]             reg_addr,
  input  wire logic [PCW_DATA_W-1:0]             reg_wdata,
  input  wire logic                              reg_write,
  input  wire logic                              reg_read,
  output logic      [PCW_DATA_W-1:0]             reg_rdata,
  // Pin inputs from the pads
  input  wire logic [NUM_PINS-1:0]               pin_in,
  // DMA completion, one pulse per pin
  input  wire logic [NUM_PINS-1:0]               dma_done,
  // Pad configuration
  output logic      [NUM_PINS-1:0][PCW_MUX_W-1:0] pin_mux,
  output logic      [NUM_PINS-1:0]               drive_strength_sel,
  output logic      [NUM_PINS-1:0]               passive_filter_on,
  output logic      [NUM_PINS-1:0]               slew_rate_sel,
  output logic      [NUM_PINS-1:0]               pull_on,
  output logic      [NUM_PINS-1:0]               pull_direction,
  // Requests
  output logic      [NUM_PINS-1:0]               dma_req,
  output logic                                   port_irq
);

  // ==========================================================================
  // Storage
  logic [NUM_PINS-1:0][PCW_SEL_W-1:0] event_select;
  logic [NUM_PINS-1:0]                irq_mask;
  logic [NUM_PINS-1:0]                pin_sync;
  logic [NUM_PINS-1:0]                pin_event_flag;
  logic [NUM_PINS-1:0]                irq_req;
  logic [NUM_PINS-1:0]                word_clear;
  logic [NUM_PINS-1:0]                status_clear;
  logic [NUM_PINS-1:0]                sw_clear;

  // ==========================================================================
  // Address decode
  logic                     in_pin_area;
  logic                     aligned;
  logic                     pin_hit;
  logic                     status_hit;
  logic                     mask_hit;
  logic [PCW_PIN_IDX_W-1:0] pin_idx;
  logic [PCW_DATA_W-1:0]    next_rdata;

  // Pin words occupy the lower half, four bytes each
  assign in_pin_area = ~reg_addr[PCW_AREA_BIT];
  assign aligned     = (reg_addr[PCW_IDX_LSB-1:0] == '0);
  assign pin_idx     = reg_addr[PCW_IDX_LSB +: PCW_PIN_IDX_W];
  assign pin_hit     = in_pin_area & aligned &
                       (32'(pin_idx) < NUM_PINS);
  assign status_hit  = (reg_addr == PCW_OFS_STATUS);
  assign mask_hit    = (reg_addr == PCW_OFS_MASK);

  // ==========================================================================
  // Pin synchroniser
  pcw_sync #(
    .W       (NUM_PINS)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       (pin_in),
    .q       (pin_sync)
  );

  // ==========================================================================
  // Pad configuration fields
  // Reset loads per-port values; unbonded pins start with the pad off
  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (sys_rst) begin
        pin_mux[i]            <= BONDED[i] ? RST_MUX : PCW_MUX_DISABLE;
        drive_strength_sel[i] <= RST_DRIVE;
        passive_filter_on[i]  <= RST_FILTER;
        slew_rate_sel[i]      <= RST_SLEW;
        pull_on[i]            <= RST_PULL;
        pull_direction[i]     <= RST_PDIR;
      end else if (reg_write && pin_hit && (32'(pin_idx) == i)) begin
        pin_mux[i]            <= reg_wdata[PCW_MUX_LSB +: PCW_MUX_W];
        drive_strength_sel[i] <= reg_wdata[PCW_DRIVE_BIT];
        passive_filter_on[i]  <= reg_wdata[PCW_FILTER_BIT];
        slew_rate_sel[i]      <= reg_wdata[PCW_SLEW_BIT];
        pull_on[i]            <= reg_wdata[PCW_PULL_BIT];
        pull_direction[i]     <= reg_wdata[PCW_PDIR_BIT];
      end
    end
  end

  // ==========================================================================
  // Event select field
  // Pins without event capability keep the field at off
  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (sys_rst) begin
        event_select[i] <= PCW_EV_OFF;
      end else if (reg_write && pin_hit && (32'(pin_idx) == i) && IRQ_CAPABLE[i]) begin
        event_select[i] <= reg_wdata[PCW_SEL_LSB +: PCW_SEL_W];
      end
    end
  end

  // ==========================================================================
  // Interrupt mask, one bit per pin
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_mask <= '0;
    end else if (reg_write && mask_hit) begin
      irq_mask <= reg_wdata[NUM_PINS-1:0];
    end
  end

  // ==========================================================================
  // Write-one clears, from the pin word or from the port status word
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      word_clear[i]   = reg_write & pin_hit & (32'(pin_idx) == i) &
                        reg_wdata[PCW_FLAG_BIT];
      status_clear[i] = reg_write & status_hit & reg_wdata[i];
    end
  end

  // Incapable pins never clear a flag that cannot be set
  assign sw_clear = (word_clear | status_clear) & IRQ_CAPABLE;

  // ==========================================================================
  // Per-pin detectors, independent of the mux slot
  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    pcw_pin_if pif ();

    assign pif.event_select  = event_select[g];
    assign pif.pin_level     = pin_sync[g];
    assign pif.sw_clear      = sw_clear[g];
    assign pif.dma_done      = dma_done[g];
    assign pin_event_flag[g] = pif.pin_event_flag;
    assign dma_req[g]        = pif.dma_req;
    assign irq_req[g]        = pif.irq_req;

    pcw_pin_detect u_det (
      .clk     (clk),
      .sys_rst (sys_rst),
      .p       (pif.det)
    );
  end

  // ==========================================================================
  // Port interrupt: level, high while an unmasked interrupt flag is set
  always_ff @(posedge clk) begin
    if (sys_rst) port_irq <= 1'b0;
    else         port_irq <= |(irq_req & irq_mask & ~sw_clear);
  end

  // ==========================================================================
  // Read data mux; reserved bits read zero, unmapped reads zero
  always_comb begin
    next_rdata = '0;
    if (pin_hit) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (32'(pin_idx) == i) begin
          next_rdata[PCW_FLAG_BIT]                = pin_event_flag[i];
          next_rdata[PCW_SEL_LSB +: PCW_SEL_W]    = event_select[i];
          next_rdata[PCW_MUX_LSB +: PCW_MUX_W]    = pin_mux[i];
          next_rdata[PCW_DRIVE_BIT]               = drive_strength_sel[i];
          next_rdata[PCW_FILTER_BIT]              = passive_filter_on[i];
          next_rdata[PCW_SLEW_BIT]                = slew_rate_sel[i];
          next_rdata[PCW_PULL_BIT]                = pull_on[i];
          next_rdata[PCW_PDIR_BIT]                = pull_direction[i];
        end
      end
    end else if (status_hit) begin
      next_rdata[NUM_PINS-1:0] = pin_event_flag;
    end else if (mask_hit) begin
      next_rdata[NUM_PINS-1:0] = irq_mask;
    end
  end

  // Read data register, valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst)       reg_rdata <= '0;
    else if (reg_read) reg_rdata <= next_rdata;
    else               reg_rdata <= '0;
  end

endmodule

// ### pcw_port_monitor.sv
// Checker of the pin control word port, bound to pcw_port.
// Assumes one clock and the synchronous active-high reset.
`timescale 1ns/1ps
module pcw_port_monitor
  import pcw_pkg::*;
#(
  parameter int                  NUM_PINS    = 32,
  parameter logic [NUM_PINS-1:0] IRQ_CAPABLE = '1
) (
  // Clock and reset
  input wire logic                               clk,
  input wire logic                               sys_rst,
  // Register port
  input wire logic [PCW_ADDR_W-1:0]              reg_addr,
  input wire logic                               reg_write,
  input wire logic                               reg_read,
  input wire logic [PCW_DATA_W-1:0]              reg_rdata,
  // Pins, pads and requests
  input wire logic [NUM_PINS-1:0]                pin_in,
  input wire logic [NUM_PINS-1:0]                dma_done,
  input wire logic [NUM_PINS-1:0][PCW_MUX_W-1:0] pin_mux,
  input wire logic [NUM_PINS-1:0]                pull_on,
  input wire logic [NUM_PINS-1:0]                dma_req,
  input wire logic                               port_irq
);
  // ==========================================================================
  // Helpers
  logic unmapped;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Addresses that hold no register
  assign unmapped = (reg_addr[1:0] != 2'h0) || (reg_addr[PCW_AREA_BIT] &&
                    reg_addr != PCW_OFS_STATUS && reg_addr != PCW_OFS_MASK);

  // ==========================================================================
  // Assertions
  rdata_idle_a: assert property (!reg_read |=> reg_rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  reserved_zero_a: assert property (
    reg_read && !reg_addr[PCW_AREA_BIT] |=> (reg_rdata & 32'hFEF0_F8A8) == 32'h0)
    else $error("reserved bits of a pin word read non-zero");
  unmapped_read_a: assert property (reg_read && unmapped |=> reg_rdata == 32'h0)
    else $error("unmapped read returned data");
  dma_clear_a: assert property (
    (dma_done & dma_req) != '0 |=> (dma_req & $past(dma_done & dma_req)) == '0)
    else $error("request stays after its transfer finished");
  dma_cause_a: assert property (
    (dma_req & ~$past(dma_req)) != '0 |-> $past(pin_in, 2) != $past(pin_in, 3) ||
    $past(pin_in, 3) != $past(pin_in, 4) || $past(pin_in, 4) != $past(pin_in, 5))
    else $error("request rose without a pin change");
  pad_stable_a: assert property (!reg_write |=> $stable(pin_mux) && $stable(pull_on))
    else $error("pad field changed without a write");
  reset_quiet_a: assert property ($fell(sys_rst) |-> dma_req == '0 && !port_irq)
    else $error("request active right after reset");
  irq_fall_a: assert property ($fell(port_irq) |-> $past(reg_write))
    else $error("interrupt dropped without a write");
  incapable_quiet_a: assert property ((dma_req & ~IRQ_CAPABLE) == '0)
    else $error("request from a pin without event capability");
  incapable_read_a: assert property (
    reg_read && !reg_addr[PCW_AREA_BIT] &&
    !IRQ_CAPABLE[reg_addr[PCW_IDX_LSB +: PCW_PIN_IDX_W]] |=>
    reg_rdata[PCW_FLAG_BIT:PCW_SEL_LSB] == '0)
    else $error("event field of a pin without event capability not zero");
endmodule

bind pcw_port pcw_port_monitor #(.NUM_PINS(NUM_PINS), .IRQ_CAPABLE(IRQ_CAPABLE))
  pcw_port_monitor_inst (.clk, .sys_rst, .reg_addr, .reg_write, .reg_read, .reg_rdata,
  .pin_in, .dma_done, .pin_mux, .pull_on, .dma_req, .port_irq);

// ### pcw_dma_model.sv
// Behavioural DMA controller that serves the port's requests.
// Assumes one clock; go low stalls it, dly sets its answer time.
`timescale 1ns/1ps
module pcw_dma_model #(
  parameter int N = 32
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Control from the bench
  input  wire logic         go,
  input  wire logic [3:0]   dly,
  // Port side
  input  wire logic [N-1:0] dma_req,
  output logic      [N-1:0] dma_done
);
  logic [3:0] cnt;
  // Finish pending transfers dly+1 cycles after the request, one pulse
  always_ff @(posedge clk) begin
    if (sys_rst || !go || dma_req == '0 || dma_done != '0) begin
      cnt      <= 4'h0;
      dma_done <= '0;
    end else if (cnt >= dly) begin
      cnt      <= 4'h0;
      dma_done <= dma_req;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// ### tb_top.sv
// Testbench of the pin control word port: register tests and pin events.
// Assumes pcw_port with its bound checker and the DMA model beside it.
`timescale 1ns/1ps
module tb_top
  import pcw_pkg::*;
;
  localparam logic [31:0] RST_WORD = 32'h0000_0540; // Mux 5, drive on
  logic                       clk;
  logic                       sys_rst;
  logic [PCW_ADDR_W-1:0]      reg_addr;
  logic [PCW_DATA_W-1:0]      reg_wdata;
  logic                       reg_write;
  logic                       reg_read;
  logic [PCW_DATA_W-1:0]      reg_rdata;
  logic [31:0]                pin_in;
  logic [31:0]                dma_done;
  logic [31:0][PCW_MUX_W-1:0] pin_mux;
  logic [31:0]                drv, filt, slew, pull_on, pull_dir, dma_req;
  logic                       port_irq;
  logic                       go;
  logic [3:0]                 dly;
  int                         num_errors;
  int                         n_checks;

  // ==========================================================================
  // Design and DMA partner; unbonded pin 30 is never written
  pcw_port #(.IRQ_CAPABLE(32'h7FFF_FFFF), .BONDED(32'hBFFF_FFFF), .RST_MUX(3'h5),
    .RST_DRIVE(1'b1)) pcw_port_inst (.clk, .sys_rst, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .pin_in, .dma_done, .pin_mux,
    .drive_strength_sel(drv), .passive_filter_on(filt), .slew_rate_sel(slew),
    .pull_on, .pull_direction(pull_dir), .dma_req, .port_irq);
  pcw_dma_model pcw_dma_model_inst (.clk, .sys_rst, .go, .dly, .dma_req, .dma_done);

  // Clock of 25 ns
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    chk("reg_rdata", exp, reg_rdata);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // Expect a request on pin 1 or none, then let the model finish it
  task automatic dma_ev(input logic exp);
    settle(5);
    chk("dma_req", {31'h0, exp}, {31'h0, dma_req[1]});
    @(posedge clk) go <= 1'b1;
    settle(12);
    chk("dma_req done", 32'h0, {31'h0, dma_req[1]});
    @(posedge clk) go <= 1'b0;
  endtask
  // Move pin 2, check the interrupt, clear it and check again
  task automatic lv(input logic v, input logic exp, input logic again);
    @(posedge clk) pin_in[2] <= v;
    settle(5);
    chk("port_irq", {31'h0, exp}, {31'h0, port_irq});
    wr(PCW_OFS_STATUS, 32'h0000_0004);
    settle(3);
    chk("port_irq cleared", {31'h0, again}, {31'h0, port_irq});
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {reg_addr, reg_wdata, reg_write, reg_read, pin_in, go, dly} = '0;
    sys_rst = 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h00, RST_WORD);
    rd(8'h78, 32'h0000_0040);
    chk("pin_mux 30", 32'h0, {29'h0, pin_mux[30]});
    rd(PCW_OFS_STATUS, 32'h0);
    rd(PCW_OFS_MASK, 32'h0);
    rd(8'h90, 32'h0);
    rd(8'h02, 32'h0);
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00, 32'h000F_0757);
    chk("pads pin 0", 32'h0000_000F, {28'h0, pin_mux[0], pull_dir[0]});
    chk("pads pin 0 rest", 32'h0000_000F, {28'h0, drv[0], filt[0], slew[0], pull_on[0]});
    wr(8'h7C, RST_WORD | 32'h0009_0000);
    rd(8'h7C, RST_WORD);
    $display("test registers done");
    for (int c = 1; c <= 3; c++) begin
      dly <= (c == 2) ? 4'h5 : 4'h0;
      wr(8'h04, RST_WORD | (32'(c) << 16));
      @(posedge clk) pin_in[1] <= 1'b1;
      dma_ev(c != 2);
      @(posedge clk) pin_in[1] <= 1'b0;
      dma_ev(c != 1);
    end
    wr(8'h04, RST_WORD);
    $display("test dma codes done");
    for (int c = 0; c < 16; c++) begin
      if (!(c inside {[1:3], [8:12]})) begin
        wr(8'h00, RST_WORD | (32'(c) << 16));
        @(posedge clk) pin_in[0] <= 1'b1;
        settle(4);
        @(posedge clk) pin_in[0] <= 1'b0;
        settle(4);
        rd(PCW_OFS_STATUS, 32'h0);
      end
    end
    $display("test reserved codes done");
    wr(PCW_OFS_MASK, 32'h0000_0004);
    for (int c = 8; c <= 12; c++) begin
      wr(8'h08, RST_WORD | 32'h0100_0000);
      wr(PCW_OFS_STATUS, 32'h0000_0004);
      wr(8'h08, RST_WORD | (32'(c) << 16));
      lv(1'b0, c == 8, c == 8);
      lv(1'b1, c inside {8, 9, 11, 12}, c == 12);
      lv(1'b0, c inside {8, 10, 11, 12}, c == 8);
    end
    wr(8'h08, RST_WORD);
    wr(PCW_OFS_STATUS, 32'h0000_0004);
    $display("test interrupt codes done");
    wr(PCW_OFS_MASK, 32'h0);
    wr(8'h08, RST_WORD | 32'h0009_0000);
    @(posedge clk) pin_in[2] <= 1'b1;
    settle(5);
    chk("port_irq masked", 32'h0, {31'h0, port_irq});
    wr(PCW_OFS_STATUS, 32'h0);
    rd(8'h08, RST_WORD | 32'h0109_0000);
    rd(PCW_OFS_STATUS, 32'h0000_0004);
    wr(PCW_OFS_MASK, 32'h0000_0004);
    settle(2);
    chk("port_irq unmasked", 32'h1, {31'h0, port_irq});
    wr(8'h08, RST_WORD | 32'h0109_0000);
    settle(1);
    chk("port_irq after w1c", 32'h0, {31'h0, port_irq});
    rd(8'h08, RST_WORD | 32'h0009_0000);
    $display("test mask and clear done");
    end_of_test();
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
endmodule
